// ### include/mcpwm_pkg.sv
// Purpose: Shared constants of the multi-channel pulse width timer.
// Assumes: 32-bit AXI4-Lite register access, one clock.
// Notes:   Register offsets are byte addresses.
package mcpwm_pkg;
    localparam int          NUM_SLOTS    = 7;
    localparam int          NUM_OUTS     = 6;
    localparam int          CW           = 32;
    localparam logic [7:0]  ADDR_CTRL    = 8'h00;
    localparam logic [7:0]  ADDR_COUNT   = 8'h04;
    localparam logic [7:0]  ADDR_PRESC   = 8'h08;
    localparam logic [7:0]  ADDR_PCOUNT  = 8'h0c;
    localparam logic [7:0]  ADDR_MCTRL   = 8'h10;
    localparam logic [7:0]  ADDR_OCTRL   = 8'h14;
    localparam logic [7:0]  ADDR_LATCH   = 8'h18;
    localparam logic [7:0]  ADDR_IRQSTAT = 8'h1c;
    localparam logic [7:0]  ADDR_IRQCLR  = 8'h20;
    localparam logic [7:0]  ADDR_IRQEN   = 8'h24;
    localparam logic [7:0]  ADDR_MATCH0  = 8'h40;
    localparam logic [7:0]  ADDR_STEP    = 8'h04;
    localparam int          CTRL_RUN     = 0;
    localparam int          CTRL_CLR     = 1;
    localparam int          CTRL_PWM     = 2;
    localparam int          MC_IRQ       = 0;
    localparam int          MC_RST       = 1;
    localparam int          MC_STOP      = 2;
    localparam int          MC_W         = 3;
    localparam int          OC_EN        = 0;
    localparam int          OC_DBL       = 8;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
    localparam logic [CW-1:0] ZERO       = 32'h00000000;
    localparam logic [CW-1:0] ONE        = 32'h00000001;
endpackage

// ### include/mcpwm_match_if.sv
// Purpose: Carries counter state and match results between timer modules.
// Assumes: One clock domain.
// Notes:   Core drives count and released match values, matcher drives hits.
`timescale 1ns/1ps
`default_nettype none
interface mcpwm_match_if;
    import mcpwm_pkg::*;
    logic [CW-1:0]        count;
    logic [CW-1:0]        match [NUM_SLOTS];
    logic [NUM_SLOTS-1:0] hit;
    modport core (output count, output match, input hit);
    modport cmp  (input count, input match, output hit);
endinterface
`default_nettype wire

// ### verilog/mcpwm_cmp.sv
// Purpose: Compares the counter against every active match slot.
// Assumes: Match values are the released copies.
// Notes:   Purely combinational.
`timescale 1ns/1ps
`default_nettype none
module mcpwm_cmp
    import mcpwm_pkg::*;
(
    // Match bundle
    mcpwm_match_if.cmp m
);
    genvar i;
    generate
        for (i = 0; i < NUM_SLOTS; i++) begin : gSlot
            assign m.hit[i] = (m.count == m.match[i]);
        end
    endgenerate
endmodule
`default_nettype wire

// ### verilog/mcpwm_out.sv
// Purpose: Forms one modulated output from slot hits.
// Assumes: Hits are combinational levels from the comparator, qualified here by tick.
// Notes:   Output index n uses slot n+1; double edge also uses slot n.
`timescale 1ns/1ps
`default_nettype none
module mcpwm_out (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Control
    input  wire logic pwmOn,
    input  wire logic outEn,
    input  wire logic dbl,
    input  wire logic tick,
    // Match hits
    input  wire logic hitPeriod,
    input  wire logic hitRise,
    input  wire logic hitFall,
    // Output
    output var  logic pwmOut
);
    logic lvl_r;
    logic lvl_nxt;
    always_comb begin
        lvl_nxt = lvl_r;
        if (!pwmOn || !outEn) begin
            lvl_nxt = 1'b0;
        end else if (tick) begin
            if (dbl) begin
                // Fall before rise gives negative pulse.
                if (hitFall) begin
                    lvl_nxt = 1'b0;
                end else if (hitRise) begin
                    lvl_nxt = 1'b1;
                end
            end else begin
                if (hitFall) begin
                    lvl_nxt = 1'b0;
                end else if (hitPeriod) begin
                    lvl_nxt = 1'b1;
                end
            end
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            lvl_r <= 1'b0;
        end else begin
            lvl_r <= lvl_nxt;
        end
    end
    assign pwmOut = lvl_r;
endmodule
`default_nettype wire

// ### verilog/mcpwm_timer.sv
// Purpose: Multi-channel pulse width timer with AXI4-Lite registers.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Match writes go to shadow copies; a latch-enable write releases them.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Seven slots, six single or three double.
// - Slot zero match clears the counter in modulation mode.
// - Single output rises at period when the prescaler is zero, never otherwise; falls own.
// - Double output uses rise and fall slots.
// - Either edge anywhere; pulse polarity follows.
// - Period and width any whole tick count when the prescaler is zero.
// - Per slot: interrupt, stop or reset.
// - Released match values apply at period in modulation mode, at once otherwise.
// - Without modulation, plain timer behaviour.
// - Thirty-two bit counter and prescaler.
// - Counting runs on peripheral clock.
module mcpwm_timer
    import mcpwm_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // AXI4-Lite write address
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output var  logic                 s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output var  logic                 s_axi_wready,
    // AXI4-Lite write response
    output var  logic [1:0]           s_axi_bresp,
    output var  logic                 s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output var  logic                 s_axi_arready,
    output var  logic [31:0]          s_axi_rdata,
    output var  logic [1:0]           s_axi_rresp,
    output var  logic                 s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // Outputs
    output var  logic [NUM_OUTS-1:0]  pwmOut,
    output var  logic                 irq
);
    typedef struct packed {
        logic                 awHave;
        logic [7:0]           awAddr;
        logic                 wHave;
        logic [31:0]          wData;
        logic [3:0]           wStrb;
        logic                 bValid;
        logic [1:0]           bResp;
        logic                 rValid;
        logic [31:0]          rData;
        logic [1:0]           rResp;
        logic [2:0]           ctrl;
        logic [CW-1:0]        count;
        logic [CW-1:0]        presc;
        logic [CW-1:0]        pcount;
        logic [NUM_SLOTS*MC_W-1:0] mctrl;
        logic [15:0]          octrl;
        logic [NUM_SLOTS-1:0] latch;
        logic [NUM_SLOTS-1:0] irqStat;
        logic [NUM_SLOTS-1:0] irqEn;
        logic                 irq;
        logic [NUM_SLOTS*CW-1:0] shadow;
        logic [NUM_SLOTS*CW-1:0] match;
        logic [NUM_SLOTS-1:0] hitSeen;
    } mcpwm_state_t;

    mcpwm_state_t s_r;
    mcpwm_state_t s_nxt;
    mcpwm_match_if mbus ();
    logic tick;
    logic [NUM_SLOTS-1:0] hitNew;

    ////////////////////////////////////////////////////////////////////////////
    // Comparators and output stages.
    assign mbus.count = s_r.count;
    genvar g;
    generate
        for (g = 0; g < NUM_SLOTS; g++) begin : gMatch
            assign mbus.match[g] = s_r.match[g*CW +: CW];
        end
        for (g = 0; g < NUM_OUTS; g++) begin : gOut
            mcpwm_out uOut (
                .clk       (clk),
                .rst       (rst),
                .pwmOn     (s_r.ctrl[CTRL_PWM]),
                .outEn     (s_r.octrl[OC_EN + g]),
                .dbl       (s_r.octrl[OC_DBL + g] && (g > 0)),
                .tick      (tick),
                .hitPeriod (mbus.hit[0]),
                .hitRise   (mbus.hit[g]),
                .hitFall   (mbus.hit[g+1]),
                .pwmOut    (pwmOut[g])
            );
        end
    endgenerate
    mcpwm_cmp uCmp (
        .m (mbus.cmp)
    );

    assign tick = s_r.ctrl[CTRL_RUN] && !s_r.ctrl[CTRL_CLR] && (s_r.pcount == s_r.presc);
    // A hit acts once, on the first cycle the counter sits on the value.
    assign hitNew = mbus.hit & ~s_r.hitSeen;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic.
    always_comb begin
        logic [31:0] wd;
        logic [7:0]  wa;
        logic        doW;
        logic        doR;
        logic        rst0;
        logic        stop0;
        logic [NUM_SLOTS-1:0] evt;
        logic [NUM_SLOTS-1:0] clrMask;
        int k;
        wd = 32'h00000000;
        wa = 8'h00;
        doW = 1'b0;
        doR = 1'b0;
        k = 0;
        rst0 = 1'b0;
        stop0 = 1'b0;
        evt = '0;
        clrMask = '0;
        s_nxt = s_r;

        // Write channel capture, either order, refused while a response waits.
        if (s_axi_awvalid && !s_r.awHave && !s_r.bValid) begin
            s_nxt.awHave = 1'b1;
            s_nxt.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_r.wHave && !s_r.bValid) begin
            s_nxt.wHave = 1'b1;
            s_nxt.wData = s_axi_wdata;
            s_nxt.wStrb = s_axi_wstrb;
        end
        doW = s_r.awHave && s_r.wHave && !s_r.bValid;
        if (s_r.bValid && s_axi_bready) begin
            s_nxt.bValid = 1'b0;
        end
        for (k = 0; k < 4; k++) begin
            wd[k*8 +: 8] = s_r.wStrb[k] ? s_r.wData[k*8 +: 8] : 8'h00;
        end
        wa = s_r.awAddr;

        if (s_r.ctrl[CTRL_CLR]) begin
            s_nxt.pcount = ZERO;
            s_nxt.count = ZERO;
        end else if (s_r.ctrl[CTRL_RUN]) begin
            if (tick) begin
                s_nxt.pcount = ZERO;
                s_nxt.count = s_r.count + ONE;
            end else begin
                s_nxt.pcount = s_r.pcount + ONE;
            end
        end

        if (s_r.ctrl[CTRL_RUN] && !s_r.ctrl[CTRL_CLR]) begin
            evt = hitNew;
            for (k = 0; k < NUM_SLOTS; k++) begin
                if (evt[k] && s_r.mctrl[k*MC_W + MC_RST]) begin
                    rst0 = 1'b1;
                end
                if (evt[k] && s_r.mctrl[k*MC_W + MC_STOP]) begin
                    stop0 = 1'b1;
                end
            end
        end
        s_nxt.hitSeen = mbus.hit;
        // Slot zero clears counter in modulation mode.
        if (s_r.ctrl[CTRL_PWM] && evt[0]) begin
            rst0 = 1'b1;
        end
        if (rst0) begin
            s_nxt.count = ZERO;
            s_nxt.pcount = ZERO;
        end
        if (stop0) begin
            s_nxt.ctrl[CTRL_RUN] = 1'b0;
        end

        // Released values load at period start, or at once outside modulation mode.
        if ((rst0 && s_r.ctrl[CTRL_PWM]) || !s_r.ctrl[CTRL_PWM]) begin
            for (k = 0; k < NUM_SLOTS; k++) begin
                if (s_r.latch[k]) begin
                    s_nxt.match[k*CW +: CW] = s_r.shadow[k*CW +: CW];
                end
            end
            s_nxt.latch = '0;
        end

        // Register writes.
        if (doW) begin
            s_nxt.awHave = 1'b0;
            s_nxt.wHave = 1'b0;
            s_nxt.bValid = 1'b1;
            s_nxt.bResp = RESP_OKAY;
            if (wa == ADDR_CTRL) begin
                s_nxt.ctrl = wd[2:0];
            end else if (wa == ADDR_COUNT) begin
                s_nxt.count = wd;
            end else if (wa == ADDR_PRESC) begin
                s_nxt.presc = wd;
            end else if (wa == ADDR_PCOUNT) begin
                s_nxt.pcount = wd;
            end else if (wa == ADDR_MCTRL) begin
                s_nxt.mctrl = wd[NUM_SLOTS*MC_W-1:0];
            end else if (wa == ADDR_OCTRL) begin
                s_nxt.octrl = wd[15:0];
            end else if (wa == ADDR_LATCH) begin
                s_nxt.latch = s_nxt.latch | wd[NUM_SLOTS-1:0];
            end else if (wa == ADDR_IRQCLR) begin
                clrMask = wd[NUM_SLOTS-1:0];
            end else if (wa == ADDR_IRQEN) begin
                s_nxt.irqEn = wd[NUM_SLOTS-1:0];
            end else if (wa >= ADDR_MATCH0 && wa < ADDR_MATCH0 + 8'(NUM_SLOTS * 4)) begin
                k = int'(wa - ADDR_MATCH0) / 4;
                s_nxt.shadow[k*CW +: CW] = wd;
            end else if (wa != ADDR_IRQSTAT) begin
                s_nxt.bResp = RESP_SLVERR;
            end
        end

        // Sticky status: a new event wins over a clear.
        for (k = 0; k < NUM_SLOTS; k++) begin
            if (evt[k] && s_r.mctrl[k*MC_W + MC_IRQ]) begin
                s_nxt.irqStat[k] = 1'b1;
            end else if (clrMask[k]) begin
                s_nxt.irqStat[k] = 1'b0;
            end
        end
        s_nxt.irq = |(s_nxt.irqStat & s_nxt.irqEn);

        // Register reads.
        doR = s_axi_arvalid && !s_r.rValid;
        if (s_r.rValid && s_axi_rready) begin
            s_nxt.rValid = 1'b0;
        end
        if (doR) begin
            s_nxt.rValid = 1'b1;
            s_nxt.rResp = RESP_OKAY;
            s_nxt.rData = 32'h00000000;
            if (s_axi_araddr == ADDR_CTRL) begin
                s_nxt.rData[2:0] = s_r.ctrl;
            end else if (s_axi_araddr == ADDR_COUNT) begin
                s_nxt.rData = s_r.count;
            end else if (s_axi_araddr == ADDR_PRESC) begin
                s_nxt.rData = s_r.presc;
            end else if (s_axi_araddr == ADDR_PCOUNT) begin
                s_nxt.rData = s_r.pcount;
            end else if (s_axi_araddr == ADDR_MCTRL) begin
                s_nxt.rData[NUM_SLOTS*MC_W-1:0] = s_r.mctrl;
            end else if (s_axi_araddr == ADDR_OCTRL) begin
                s_nxt.rData[15:0] = s_r.octrl;
            end else if (s_axi_araddr == ADDR_LATCH) begin
                s_nxt.rData[NUM_SLOTS-1:0] = s_r.latch;
            end else if (s_axi_araddr == ADDR_IRQSTAT) begin
                s_nxt.rData[NUM_SLOTS-1:0] = s_r.irqStat;
            end else if (s_axi_araddr == ADDR_IRQEN) begin
                s_nxt.rData[NUM_SLOTS-1:0] = s_r.irqEn;
            end else if (s_axi_araddr >= ADDR_MATCH0
                         && s_axi_araddr < ADDR_MATCH0 + 8'(NUM_SLOTS * 4)) begin
                k = int'(s_axi_araddr - ADDR_MATCH0) / 4;
                s_nxt.rData = s_r.shadow[k*CW +: CW];
            end else if (s_axi_araddr != ADDR_IRQCLR) begin
                s_nxt.rResp = RESP_SLVERR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register.
    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign s_axi_awready = !s_r.awHave && !s_r.bValid;
    assign s_axi_wready  = !s_r.wHave && !s_r.bValid;
    assign s_axi_bvalid  = s_r.bValid;
    assign s_axi_bresp   = s_r.bResp;
    assign s_axi_arready = !s_r.rValid;
    assign s_axi_rvalid  = s_r.rValid;
    assign s_axi_rdata   = s_r.rData;
    assign s_axi_rresp   = s_r.rResp;
    assign irq           = s_r.irq;
endmodule
`default_nettype wire

// ### verification/mcpwm_timer_monitor.sv
// Purpose: Port checks for the pulse width timer.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound to every timer instance.
`timescale 1ns/1ps
`default_nettype none
module mcpwm_timer_monitor
    import mcpwm_pkg::*;
(
    // Clock and reset
    input wire logic                clk,
    input wire logic                rst,
    // Register bus
    input wire logic                s_axi_awvalid,
    input wire logic                s_axi_awready,
    input wire logic                s_axi_wvalid,
    input wire logic                s_axi_wready,
    input wire logic                s_axi_bvalid,
    input wire logic                s_axi_bready,
    input wire logic                s_axi_arvalid,
    input wire logic                s_axi_arready,
    input wire logic [31:0]         s_axi_rdata,
    input wire logic                s_axi_rvalid,
    input wire logic                s_axi_rready,
    // Outputs
    input wire logic [NUM_OUTS-1:0] pwmOut,
    input wire logic                irq
);
    default clocking dcb @(posedge clk);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////
    AST_WR_ANSWER: assert property ( // write answer
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer off time");
    AST_B_HOLD: assert property ( // answer held
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
    AST_B_DROP: assert property ( // answer taken
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
        else $error("write not closed");
    AST_AW_BLOCK: assert property ( // one write
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
    AST_RD_ANSWER: assert property ( // read answer
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
    AST_R_HOLD: assert property ( // data held
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    AST_R_DROP: assert property ( // read taken
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read not closed");
    AST_RST_IDLE: assert property ( // quiet start
        $fell(rst) |-> (s_axi_awready && s_axi_wready && s_axi_arready && pwmOut == '0)
        ##1 (pwmOut == '0 && !irq) [*2]) else $error("outputs not idle after reset");
    ////////////////////////////////////////////////////////////
    cover property (s_axi_bvalid && s_axi_bready);
    cover property ($rose(irq));
    cover property ($rose(pwmOut[1]));
endmodule
bind mcpwm_timer mcpwm_timer_monitor mon (
    .clk(clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .pwmOut(pwmOut), .irq(irq));
`default_nettype wire

// ### verification/tb.sv
// Purpose: Self-checking bench for the pulse width timer.
// Assumes: Register map and bus latencies of the timer.
// Notes:   Pulse widths are counted in clocks with a prescaler of zero.
`timescale 1ns/1ps
`default_nettype none
module tb
    import mcpwm_pkg::*;
;
    logic                clk      = 1'b0;
    logic                rst      = 1'b1;
    logic [7:0]          awaddr   = 8'h00;
    logic                awvalid  = 1'b0;
    logic [31:0]         wdata    = 32'h0;
    logic                wvalid   = 1'b0;
    logic                bready   = 1'b0;
    logic [7:0]          araddr   = 8'h00;
    logic                arvalid  = 1'b0;
    logic                rready   = 1'b0;
    logic                awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]          bresp, rresp, lastResp;
    logic [31:0]         rdata, rdVal;
    logic [NUM_OUTS-1:0] pwmOut;
    int                  badCount = 0;
    int                  testsRun = 0;
    int                  h0, p0, h, p, n;
    always #50 clk = ~clk;
    mcpwm_timer uut (
        .clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pwmOut(pwmOut), .irq(irq));
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        testsRun++;
        if (g !== e) begin
            badCount++;
            $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        repeat (100) begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                lastResp = bresp;
                bready <= 1'b0;
                break;
            end
            if (bvalid) bready <= 1'b1;
        end
    endtask
    task automatic rd(input logic [7:0] a);
        araddr  <= a;
        arvalid <= 1'b1;
        repeat (100) begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                rdVal = rdata;
                lastResp = rresp;
                rready <= 1'b0;
                break;
            end
            if (rvalid) rready <= 1'b1;
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(e, rdVal);
    endtask
    task automatic meas(input int i, output int hi, output int per);
        int k;
        k = 0;
        hi = 0;
        while (pwmOut[i] !== 1'b0 && k++ < 300) @(posedge clk);
        while (pwmOut[i] !== 1'b1 && k++ < 300) @(posedge clk);
        while (pwmOut[i] === 1'b1 && k++ < 300) begin
            @(posedge clk);
            hi++;
        end
        per = hi;
        while (pwmOut[i] !== 1'b1 && k++ < 300) begin
            @(posedge clk);
            per++;
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", testsRun, badCount);
        if (badCount == 0 && testsRun > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk);
        badCount++;
        end_of_test();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd(8'h30);
        chk({30'h0, RESP_SLVERR}, {30'h0, lastResp}); // unmapped place
        wr(ADDR_MATCH0 + 8'h0c, 32'h12345678);
        rchk(ADDR_MATCH0 + 8'h0c, 32'h12345678); // shadow readback
        wr(ADDR_IRQSTAT, 32'hffffffff);
        chk({30'h0, RESP_OKAY}, {30'h0, lastResp}); // status write
        rchk(ADDR_IRQSTAT, ZERO); // status read-only
        $display("test bus done");
        wr(ADDR_MATCH0 + 8'h04, 32'h14);
        wr(ADDR_LATCH, 32'h02);
        wr(ADDR_MCTRL, 32'h28);
        wr(ADDR_IRQEN, 32'h02);
        wr(ADDR_PRESC, 32'h03);
        wr(ADDR_CTRL, 32'h01);
        n = 0;
        while (irq !== 1'b1 && n++ < 300) @(posedge clk);
        chk(ONE, 32'(n >= 72 && n <= 88)); // prescaled tick
        rchk(ADDR_COUNT, 32'h14); // counter halted
        rchk(ADDR_CTRL, ZERO); // run cleared
        wr(ADDR_IRQEN, ZERO);
        chk(ZERO, {31'h0, irq}); // interrupt masked
        rchk(ADDR_IRQSTAT, 32'h02); // status sticky
        wr(ADDR_IRQCLR, 32'h02);
        rchk(ADDR_IRQSTAT, ZERO); // status cleared
        $display("test timer done");
        rst <= 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        wr(ADDR_MATCH0, 32'h0a);
        wr(ADDR_MATCH0 + 8'h04, 32'h03);
        wr(ADDR_MATCH0 + 8'h08, 32'h07);
        wr(ADDR_LATCH, 32'h07);
        wr(ADDR_OCTRL, 32'h03);
        wr(ADDR_CTRL, 32'h05);
        meas(0, h, p);
        meas(0, h0, p0);
        meas(1, h, p);
        chk(ONE, 32'(p0 == 10 || p0 == 11)); // period length
        chk(32'(p0), 32'(p)); // common rate
        chk(32'(h0 + 4), 32'(h)); // own fall slot
        chk(32'(p0 - 7), 32'(h0)); // rise at period
        wr(ADDR_MATCH0 + 8'h04, 32'h05);
        meas(0, h, p);
        meas(0, h, p);
        chk(32'(h0), 32'(h)); // held until release
        wr(ADDR_LATCH, 32'h02);
        meas(0, h, p);
        meas(0, h, p);
        chk(32'(h0 + 2), 32'(h)); // released value used
        $display("test single edge done");
        wr(ADDR_OCTRL, 32'h0203);
        meas(1, h, p);
        meas(1, h, p);
        chk(32'h02, 32'(h)); // positive pulse
        wr(ADDR_MATCH0 + 8'h04, 32'h08);
        wr(ADDR_LATCH, 32'h02);
        meas(1, h, p);
        meas(1, h, p);
        chk(32'(p0 - 1), 32'(h)); // negative pulse
        $display("test double edge done");
        wr(ADDR_CTRL, 32'h01);
        n = 0;
        repeat (40) begin
            @(posedge clk);
            if (pwmOut !== '0) n++;
        end
        chk(ZERO, 32'(n)); // timer mode quiet
        $display("test timer mode done");
        end_of_test();
    end
endmodule
`default_nettype wire
